// ### dccr_pkg.sv
// constants for the clock conditioning register bank
package dccr_pkg;

    // serial port framing
    localparam int ADDR_W = 15;
    localparam int INSTR_LAST = 15;
    localparam int DATA_LAST = 7;
    localparam int RW_BIT = 15;

    // register addresses
    localparam logic [14:0] DUTY_ADDR = 15'h0082;
    localparam logic [14:0] CROSS_ADDR = 15'h0083;
    localparam logic [14:0] SYNTHREF_ADDR = 15'h0084;
    localparam logic [14:0] FRAMECTL_ADDR = 15'h0088;
    localparam logic [14:0] HYSLOW_ADDR = 15'h0089;
    localparam logic [14:0] DLLPWR_ADDR = 15'h0090;
    localparam logic [14:0] DLLCTRL_ADDR = 15'h0091;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] DUTY_MASK = 8'hFF;
    localparam logic [7:0] CROSS_MASK = 8'h8F;
    localparam logic [7:0] SYNTHREF_MASK = 8'h31;
    localparam logic [7:0] FRAMECTL_MASK = 8'h0F;
    localparam logic [7:0] HYSLOW_MASK = 8'hFF;
    localparam logic [7:0] DLLPWR_MASK = 8'h1F;
    localparam logic [7:0] DLLCTRL_MASK = 8'hFF;

    // reset values
    localparam logic [7:0] DUTY_RST = 8'h80;
    localparam logic [7:0] CROSS_RST = 8'h80;
    localparam logic [7:0] SYNTHREF_RST = 8'h00;
    localparam logic [7:0] FRAMECTL_RST = 8'h00;
    localparam logic [7:0] HYSLOW_RST = 8'h00;
    localparam logic [7:0] DLLPWR_RST = 8'h1F;
    localparam logic [7:0] DLLCTRL_RST = 8'hF0;

    // field positions
    localparam int DUTY_EN_BIT = 7;
    localparam int DUTY_OFFSET_EN_BIT = 6;
    localparam int DUTY_BOOST_BIT = 5;
    localparam int DUTY_SIGN_BIT = 4;
    localparam int DUTY_MAG_HI = 3;
    localparam int CROSS_EN_BIT = 7;
    localparam int CROSS_ADJ_HI = 3;
    localparam int REF_RATE_HI = 5;
    localparam int REF_RATE_LO = 4;
    localparam int REF_PD_BIT = 0;
    localparam int HYS_EN_BIT = 3;
    localparam int EDGE_SEL_BIT = 2;
    localparam int HYS_HI_MSB = 1;
    localparam int FINE_DC_BIT = 4;
    localparam int FINE_XC_BIT = 3;
    localparam int COARSE_DC_BIT = 2;
    localparam int COARSE_XC_BIT = 1;
    localparam int DELAY_LOOP_POWER_CONTROL_BIT = 0;
    localparam int DLL_ENABLE_BIT = 0;

    // reference rate codes
    localparam logic [1:0] RATE_SINGLE = 2'h0;
    localparam logic [1:0] RATE_DOUBLE = 2'h1;
    localparam logic [1:0] RATE_QUAD = 2'h2;
    localparam logic [1:0] RATE_OFF = 2'h3;

    // serial port phase
    typedef enum logic {PHASE_INSTR, PHASE_DATA} dccr_phase_t;

endpackage : dccr_pkg

// ### dccr_regs.sv
// clock conditioning register bank behind the configuration serial port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - duty offset bits 4:0 sign-magnitude, sign on top, magnitude 0 to 15
// - duty register bit 7 enables duty cycle control, resets to one
// - duty register bit 6 gates the offset, resets to zero
// - duty register bit 5 selects boosted range, resets to zero
// - crossing register: enable bit 7 resets one, adjust bits 3:0 reset zero
// - rate bits 5:4 pick 1x, 2x, 4x or reference off; resets to 00
// - reference register bit 0 powers down synth reference, resets zero
// - frame control bit 3 enables receiver hysteresis, resets zero
// - frame control bit 2 selects rising edge capture, resets zero
// - ten-bit hysteresis: top two bits in control, low byte next register
// - delay-loop power bit 0 powers down loop and clock generator, resets one
// - power register bits 4 and 3 enable fine line corrections, reset one
// - power register bits 2 and 1 enable coarse line corrections, reset one
// - loop controller enable picks static settings or feedback, resets zero
module dccr_regs
    import dccr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // configuration serial port
    input wire logic spiSelect_n,
    input wire logic spiClock,
    input wire logic spiDataIn,
    output logic spiDataOut,
    output logic spiDataOutEnable,
    // duty cycle controls
    output logic dutyControlEnable,
    output logic dutyOffsetEnable,
    output logic dutyBoostEnable,
    output logic [4:0] duty_offset_value,
    output logic [4:0] appliedDutyOffset,
    // crossing point controls
    output logic crossing_adjust_enable,
    output logic [3:0] crossing_point_value,
    // synthesizer reference controls
    output logic [1:0] synthReferenceRate,
    output logic synth_reference_powerdown,
    output logic synthReferenceActive,
    output logic [2:0] synthReferenceMultiplier,
    // frame reference receiver controls
    output logic frame_ref_hysteresis_enable,
    output logic frame_ref_edge_select,
    output logic [9:0] frame_ref_hysteresis_amount,
    // delay-locked loop controls
    output logic delay_loop_powerdown,
    output logic fine_line_duty_correct_enable,
    output logic fine_line_crossing_enable,
    output logic coarse_line_duty_correct_enable,
    output logic coarse_line_crossing_enable,
    output logic [7:0] delayLoopControl,
    output logic delayLoopFeedbackEnable
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rstMeta;
    logic rstSyncN;

    // asynchronous assertion, release through two flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [7:0] dutyReg;
    logic [7:0] crossReg;
    logic [7:0] synthRefReg;
    logic [7:0] frameCtlReg;
    logic [7:0] hysLowReg;
    logic [7:0] dllPwrReg;
    logic [7:0] dllCtrlReg;

    // read mux; reserved bits masked so they always return zero
    function automatic logic [7:0] readValue(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            DUTY_ADDR: v = dutyReg & DUTY_MASK;
            CROSS_ADDR: v = crossReg & CROSS_MASK;
            SYNTHREF_ADDR: v = synthRefReg & SYNTHREF_MASK;
            FRAMECTL_ADDR: v = frameCtlReg & FRAMECTL_MASK;
            HYSLOW_ADDR: v = hysLowReg & HYSLOW_MASK;
            DLLPWR_ADDR: v = dllPwrReg & DLLPWR_MASK;
            DLLCTRL_ADDR: v = dllCtrlReg & DLLCTRL_MASK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : readValue

    ////////////////////////////////////////////////////////////////////////////
    // serial port: 16-bit instruction (read flag, 15-bit address), then bytes

    dccr_phase_t phase;
    logic sclkPrev;
    logic [3:0] bitCount;
    logic [15:0] shiftIn;
    logic readCycle;
    logic [14:0] accessAddr;
    logic [7:0] txShift;
    logic wrStb;
    logic [14:0] wrAddr;
    logic [7:0] wrData;

    // edges of the serial clock; pins are synchronous so no synchroniser
    wire sclkRise = spiClock & ~sclkPrev & ~spiSelect_n;
    wire sclkFall = ~spiClock & sclkPrev & ~spiSelect_n;
    wire [15:0] nextShift = {shiftIn[14:0], spiDataIn};
    wire [14:0] next_addr = accessAddr + 15'h0001;
    wire instrDone = sclkRise && (phase == PHASE_INSTR) && (bitCount == 4'(INSTR_LAST));
    wire byteDone = sclkRise && (phase == PHASE_DATA) && (bitCount == 4'(DATA_LAST));

    // bit counting, address capture, auto-increment after each byte
    always_ff @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            phase <= PHASE_INSTR;
            sclkPrev <= 1'b0;
            bitCount <= 4'h0;
            shiftIn <= 16'h0000;
            readCycle <= 1'b0;
            accessAddr <= 15'h0000;
        end
        else
        begin
            sclkPrev <= spiClock;
            if (spiSelect_n)
            begin
                phase <= PHASE_INSTR;
                bitCount <= 4'h0;
            end
            else if (sclkRise)
            begin
                shiftIn <= nextShift;
                bitCount <= (instrDone || byteDone) ? 4'h0 : bitCount + 4'h1;
                if (instrDone)
                begin
                    phase <= PHASE_DATA;
                    readCycle <= nextShift[RW_BIT];
                    accessAddr <= nextShift[14:0];
                end
                else if (byteDone)
                    accessAddr <= next_addr;
            end
        end
    end

    // read data shifts out on falling edges, only while selected
    always_ff @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            txShift <= 8'h00;
            spiDataOut <= 1'b0;
            spiDataOutEnable <= 1'b0;
        end
        else if (spiSelect_n)
            spiDataOutEnable <= 1'b0;
        else if (instrDone)
            txShift <= readValue(nextShift[14:0]);
        else if (byteDone)
            txShift <= readValue(next_addr);
        else if (sclkFall && phase == PHASE_DATA && readCycle)
        begin
            spiDataOut <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
            spiDataOutEnable <= 1'b1;
        end
    end

    // one-cycle write strobe once the eighth data bit is in
    always_ff @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            wrStb <= 1'b0;
            wrAddr <= 15'h0000;
            wrData <= 8'h00;
        end
        else
        begin
            wrStb <= byteDone && !readCycle;
            wrAddr <= accessAddr;
            wrData <= nextShift[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes; masks drop writes to reserved bits

    always_ff @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            dutyReg <= DUTY_RST;
            crossReg <= CROSS_RST;
            synthRefReg <= SYNTHREF_RST;
            frameCtlReg <= FRAMECTL_RST;
            hysLowReg <= HYSLOW_RST;
            dllPwrReg <= DLLPWR_RST;
            dllCtrlReg <= DLLCTRL_RST;
        end
        else if (wrStb)
        begin
            if (wrAddr == DUTY_ADDR) dutyReg <= wrData & DUTY_MASK;
            if (wrAddr == CROSS_ADDR) crossReg <= wrData & CROSS_MASK;
            if (wrAddr == SYNTHREF_ADDR) synthRefReg <= wrData & SYNTHREF_MASK;
            if (wrAddr == FRAMECTL_ADDR) frameCtlReg <= wrData & FRAMECTL_MASK;
            if (wrAddr == HYSLOW_ADDR) hysLowReg <= wrData & HYSLOW_MASK;
            if (wrAddr == DLLPWR_ADDR) dllPwrReg <= wrData & DLLPWR_MASK;
            if (wrAddr == DLLCTRL_ADDR) dllCtrlReg <= wrData & DLLCTRL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field outputs, each a direct tap of a register flop

    assign dutyControlEnable = dutyReg[DUTY_EN_BIT];
    assign dutyOffsetEnable = dutyReg[DUTY_OFFSET_EN_BIT];
    assign dutyBoostEnable = dutyReg[DUTY_BOOST_BIT];
    assign duty_offset_value = dutyReg[DUTY_SIGN_BIT:0];
    assign crossing_adjust_enable = crossReg[CROSS_EN_BIT];
    assign crossing_point_value = crossReg[CROSS_ADJ_HI:0];
    assign synthReferenceRate = synthRefReg[REF_RATE_HI:REF_RATE_LO];
    assign synth_reference_powerdown = synthRefReg[REF_PD_BIT];
    assign frame_ref_hysteresis_enable = frameCtlReg[HYS_EN_BIT];
    assign frame_ref_edge_select = frameCtlReg[EDGE_SEL_BIT];
    assign frame_ref_hysteresis_amount = {frameCtlReg[HYS_HI_MSB:0], hysLowReg};
    assign delay_loop_powerdown = dllPwrReg[DELAY_LOOP_POWER_CONTROL_BIT];
    assign fine_line_duty_correct_enable = dllPwrReg[FINE_DC_BIT];
    assign fine_line_crossing_enable = dllPwrReg[FINE_XC_BIT];
    assign coarse_line_duty_correct_enable = dllPwrReg[COARSE_DC_BIT];
    assign coarse_line_crossing_enable = dllPwrReg[COARSE_XC_BIT];
    assign delayLoopControl = dllCtrlReg;
    assign delayLoopFeedbackEnable = dllCtrlReg[DLL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // derived controls, registered so outputs stay glitch free (one cycle lag)

    // offset is zero unless both duty control and the offset gate are on
    wire offsetLive = dutyReg[DUTY_EN_BIT] & dutyReg[DUTY_OFFSET_EN_BIT];
    wire [4:0] next_applied = offsetLive ? dutyReg[DUTY_SIGN_BIT:0] : 5'h00;
    // reference runs only when not powered down and rate code is not off
    wire next_refActive = !synthRefReg[REF_PD_BIT] && (synthReferenceRate != RATE_OFF);
    wire [2:0] next_mult = (synthReferenceRate == RATE_SINGLE) ? 3'h1 :
                           (synthReferenceRate == RATE_DOUBLE) ? 3'h2 :
                           (synthReferenceRate == RATE_QUAD) ? 3'h4 : 3'h0;

    always_ff @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            appliedDutyOffset <= 5'h00;
            synthReferenceActive <= 1'b0;
            synthReferenceMultiplier <= 3'h0;
        end
        else
        begin
            appliedDutyOffset <= next_applied;
            synthReferenceActive <= next_refActive;
            synthReferenceMultiplier <= next_mult;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstSyncN);

    sequence regWrite(logic [14:0] a);
        wrStb && (wrAddr == a);
    endsequence

    sequence instrThenByte;
        instrDone ##[1:300] byteDone;
    endsequence

    reset_values_a: assert property (@(posedge ref_clk) $rose(rstSyncN) |->
        dutyReg == DUTY_RST && crossReg == CROSS_RST && dllPwrReg == DLLPWR_RST
        && dllCtrlReg == DLLCTRL_RST)
        else $error("register reset values wrong");
    duty_write_a: assert property (regWrite(DUTY_ADDR) |=>
        dutyControlEnable == $past(wrData[7]) && dutyBoostEnable == $past(wrData[5]))
        else $error("duty register write not taken");
    offset_gate_a: assert property (!dutyOffsetEnable |=> appliedDutyOffset == 5'h00)
        else $error("offset applied while gated off");
    offset_value_a: assert property (dutyOffsetEnable && dutyControlEnable |=>
        appliedDutyOffset == $past(duty_offset_value))
        else $error("applied offset differs from programmed value");
    cross_reserved_a: assert property (regWrite(CROSS_ADDR) |=>
        crossReg[6:4] == 3'h0 && crossing_point_value == $past(wrData[3:0]))
        else $error("crossing reserved bits stored");
    ref_off_a: assert property (synthReferenceRate == RATE_OFF || synth_reference_powerdown
        |=> !synthReferenceActive)
        else $error("reference active while disabled");
    ref_pd_a: assert property (regWrite(SYNTHREF_ADDR) |=>
        synth_reference_powerdown == $past(wrData[0]) && synthRefReg[3:1] == 3'h0)
        else $error("reference power-down write wrong");
    frame_ctl_a: assert property (regWrite(FRAMECTL_ADDR) |=>
        frame_ref_hysteresis_enable == $past(wrData[3]) && frame_ref_edge_select == $past(wrData[2]))
        else $error("frame control write wrong");
    edge_select_a: assert property (regWrite(FRAMECTL_ADDR) |=>
        frame_ref_edge_select == $past(wrData[2]) && frame_ref_hysteresis_amount[9:8] == $past(wrData[1:0]))
        else $error("edge select or hysteresis top bits wrong");
    hys_low_a: assert property (regWrite(HYSLOW_ADDR) |=>
        frame_ref_hysteresis_amount[7:0] == $past(wrData))
        else $error("hysteresis low byte not stored");
    dll_power_a: assert property (regWrite(DLLPWR_ADDR) |=>
        dllPwrReg == ($past(wrData) & DLLPWR_MASK))
        else $error("delay-loop power write wrong");
    fine_line_a: assert property (regWrite(DLLPWR_ADDR) |=>
        fine_line_crossing_enable == $past(wrData[3]) && coarse_line_duty_correct_enable == $past(wrData[2]))
        else $error("delay line correction enables wrong");
    dll_enable_a: assert property (regWrite(DLLCTRL_ADDR) |=>
        delayLoopFeedbackEnable == $past(wrData[0]))
        else $error("loop controller enable not stored");
    byte_strobe_a: assert property (instrThenByte ##0 !readCycle |=> wrStb)
        else $error("write strobe missing after data byte");

endmodule : dccr_regs
`default_nettype wire

// ### test_dccr_regs.sv
// self-checking bench for the clock conditioning register bank over its serial port
`timescale 1ns/1ps
`default_nettype none
module test_dccr_regs;
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic spiSelect_n = 1'b1;
    logic spiClock = 1'b0;
    logic spiDataIn = 1'b0;
    logic spiDataOut, spiDataOutEnable;
    logic dutyControlEnable, dutyOffsetEnable, dutyBoostEnable;
    logic [4:0] duty_offset_value, appliedDutyOffset;
    logic crossing_adjust_enable;
    logic [3:0] crossing_point_value;
    logic [1:0] synthReferenceRate;
    logic synth_reference_powerdown, synthReferenceActive;
    logic [2:0] synthReferenceMultiplier;
    logic frame_ref_hysteresis_enable, frame_ref_edge_select;
    logic [9:0] frame_ref_hysteresis_amount;
    logic delay_loop_powerdown, fine_line_duty_correct_enable, fine_line_crossing_enable;
    logic coarse_line_duty_correct_enable, coarse_line_crossing_enable, delayLoopFeedbackEnable;
    logic [7:0] delayLoopControl;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    // address table; the last entry is an unmapped place that must read zero
    logic [14:0] addrs [0:7] = '{15'h0082, 15'h0083, 15'h0084, 15'h0088, 15'h0089, 15'h0090, 15'h0091, 15'h0085};
    logic [7:0] masks [0:7] = '{8'hFF, 8'h8F, 8'h31, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'h00};
    logic [7:0] m [0:7] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hF0, 8'h00};
    logic [7:0] pats [0:6] = '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'hDF, 8'h4F, 8'h8F};

    always #12.5 ref_clk = ~ref_clk;

    dccr_regs u_dccr_regs (.ref_clk, .reset_n, .spiSelect_n, .spiClock, .spiDataIn, .spiDataOut,
        .spiDataOutEnable, .dutyControlEnable, .dutyOffsetEnable, .dutyBoostEnable, .duty_offset_value,
        .appliedDutyOffset, .crossing_adjust_enable, .crossing_point_value, .synthReferenceRate,
        .synth_reference_powerdown, .synthReferenceActive, .synthReferenceMultiplier,
        .frame_ref_hysteresis_enable, .frame_ref_edge_select, .frame_ref_hysteresis_amount,
        .delay_loop_powerdown, .fine_line_duty_correct_enable, .fine_line_crossing_enable,
        .coarse_line_duty_correct_enable, .coarse_line_crossing_enable, .delayLoopControl,
        .delayLoopFeedbackEnable);

    ////////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // a hung handshake would otherwise run forever
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial port master; each clock phase is held several ref_clk cycles, above the two-cycle minimum
    task automatic spi_bit(input logic b, output logic r);
        spiDataIn <= b;
        repeat (4) @(posedge ref_clk);
        #1 r = spiDataOut;
        @(posedge ref_clk);
        spiClock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        spiClock <= 1'b0;
    endtask : spi_bit

    task automatic spi_start(input logic rw, input logic [14:0] addr);
        logic [15:0] instr;
        logic r;
        instr = {rw, addr};
        // callers may return off the edge; select only moves on a rising edge
        @(posedge ref_clk);
        spiSelect_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int i = 15; i >= 0; i--)
            spi_bit(instr[i], r);
    endtask : spi_start

    task automatic spi_byte(input logic [7:0] w, output logic [7:0] r);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            spi_bit(w[i], b);
            r[i] = b;
        end
    endtask : spi_byte

    task automatic spi_stop();
        repeat (4) @(posedge ref_clk);
        spiSelect_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : spi_stop

    // the mirror keeps only writable bits, so reserved bits are expected back as zero
    task automatic reg_write(input int i, input logic [7:0] d);
        logic [7:0] r;
        spi_start(1'b0, addrs[i]);
        spi_byte(d, r);
        spi_stop();
        m[i] = d & masks[i];
    endtask : reg_write

    task automatic reg_read(input int i);
        logic [7:0] r;
        spi_start(1'b1, addrs[i]);
        spi_byte(8'h00, r);
        check("read data", r, m[i]);
        check("out enable on", spiDataOutEnable, 1'b1);
        spi_stop();
        #1 check("out enable off", spiDataOutEnable, 1'b0);
    endtask : reg_read

    ////////////////////////////////////////////////////////////////////////////////
    // every control output is compared with what the mirrored registers imply
    task automatic check_ports();
        logic [2:0] mul;
        mul = (m[2][5:4] == 2'h0) ? 3'h1 : (m[2][5:4] == 2'h1) ? 3'h2 : (m[2][5:4] == 2'h2) ? 3'h4 : 3'h0;
        check("duty enable", dutyControlEnable, m[0][7]);
        check("offset enable", dutyOffsetEnable, m[0][6]);
        check("boost", dutyBoostEnable, m[0][5]);
        check("offset", duty_offset_value, m[0][4:0]);
        check("applied", appliedDutyOffset, (m[0][7] & m[0][6]) ? m[0][4:0] : 5'h00);
        check("cross enable", crossing_adjust_enable, m[1][7]);
        check("cross value", crossing_point_value, m[1][3:0]);
        check("rate", synthReferenceRate, m[2][5:4]);
        check("multiplier", synthReferenceMultiplier, mul);
        check("ref pd", synth_reference_powerdown, m[2][0]);
        check("ref active", synthReferenceActive, !m[2][0] && m[2][5:4] != 2'h3);
        check("hys enable", frame_ref_hysteresis_enable, m[3][3]);
        check("edge select", frame_ref_edge_select, m[3][2]);
        check("hys amount", frame_ref_hysteresis_amount, {m[3][1:0], m[4]});
        check("loop pd", delay_loop_powerdown, m[5][0]);
        check("fine dc", fine_line_duty_correct_enable, m[5][4]);
        check("fine xc", fine_line_crossing_enable, m[5][3]);
        check("coarse dc", coarse_line_duty_correct_enable, m[5][2]);
        check("coarse xc", coarse_line_crossing_enable, m[5][1]);
        check("loop ctrl", delayLoopControl, m[6]);
        check("feedback", delayLoopFeedbackEnable, m[6][0]);
    endtask : check_ports

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [7:0] r;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // reset values at the ports and over the port
        #1 check_ports();
        for (int i = 0; i < 8; i++)
            reg_read(i);
        // patterns over every place, unmapped included
        foreach (pats[p])
        begin
            for (int i = 0; i < 8; i++)
                reg_write(i, pats[p]);
            check_ports();
            for (int i = 0; i < 8; i++)
                reg_read(i);
        end
        // every rate code, then power-down on top of a running rate
        for (int k = 0; k < 4; k++)
        begin
            reg_write(2, {2'h0, k[1:0], 4'h0});
            check_ports();
        end
        reg_write(2, 8'h21);
        check_ports();
        // two bytes in one frame land at consecutive addresses
        spi_start(1'b0, 15'h0088);
        spi_byte(8'h0E, r);
        spi_byte(8'h5A, r);
        spi_stop();
        m[3] = 8'h0E;
        m[4] = 8'h5A;
        check_ports();
        reg_read(3);
        reg_read(4);
        // loop power and controller fields set separately
        reg_write(5, 8'h0A);
        reg_write(6, 8'h01);
        check_ports();
        // a byte cut short by select must not reach the register
        spi_start(1'b0, 15'h0083);
        for (int i = 0; i < 4; i++)
            spi_bit(1'b1, r[0]);
        spi_stop();
        check_ports();
        reg_read(1);
        end_sim();
    end
endmodule : test_dccr_regs
`default_nettype wire
